/* File: tb/cabinet_model.sv */
`timescale 1ns/1ps
module cabinet_model (
	input wire logic clock,
	input wire logic wdRun,
	output logic watchdogIn,
	output logic [17:0] redIn,
	output logic [17:0] yellowIn,
	output logic [17:0] greenIn,
	output logic [1:0] specialFunction,
	output logic redEnable
);
	logic [31:0] r;
	logic [2:0] cnt;
	initial begin
		watchdogIn = 1'b0;
		cnt = 3'h0;
	end
	// field levels glitch every cycle, far below any qualification time
	always @(posedge clock) begin
		r = $urandom;
		redIn <= r[17:0];
		yellowIn <= r[31:14];
		greenIn <= r[20:3];
		specialFunction <= r[1:0];
		redEnable <= r[5];
		cnt <= cnt + 3'h1;
		if (wdRun && cnt == 3'h7) watchdogIn <= !watchdogIn;
	end
endmodule : cabinet_model

/* File: tb/fault_monitor_assertions.sv */
`timescale 1ns/1ps
// ----------------------------------------
// fault latch, timing and bus checks
// ----------------------------------------
module fault_monitor_assertions #(
	parameter int CH = 18,
	parameter int WD_NEW = 100,
	parameter int WD_OLD = 150,
	parameter int BO_NEW = 80,
	parameter int BO_OLD = 20
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic watchdogIn,
	input wire logic programCardPresent,
	input wire logic redInterfaceCablePresent,
	input wire logic lineDropout,
	input wire logic logicSupplyOk,
	input wire logic frontPanelReset,
	input wire logic remoteReset,
	input wire logic faultRelayFlash,
	input wire logic [CH-1:0] yellowLamp,
	input wire logic [CH-1:0] greenLamp,
	input wire logic powerLamp,
	input wire logic logicSupplyFaultLamp,
	input wire logic watchdogTimeoutFaultLamp,
	input wire logic conflictLamp,
	input wire logic dualLamp,
	input wire logic clearanceLamp,
	input wire logic programCardAjarLamp,
	input wire logic diagnosticLamp
);
	logic [31:0] wdCnt_ff;
	logic [31:0] boCnt_ff;
	logic [2:0] qCnt_ff;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) wdCnt_ff <= '0;
		else if ($changed(watchdogIn)) wdCnt_ff <= '0;
		else wdCnt_ff <= wdCnt_ff + 32'h1;
	end
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) boCnt_ff <= '0;
		else if (!lineDropout) boCnt_ff <= '0;
		else boCnt_ff <= boCnt_ff + 32'h1;
	end
	// cycles since anything that may legally clear a fault
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) qCnt_ff <= '0;
		else if (frontPanelReset || remoteReset || lineDropout || (hsel && hwrite && htrans == 2'h2))
			qCnt_ff <= '0;
		else if (qCnt_ff != 3'h7) qCnt_ff <= qCnt_ff + 3'h1;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	sequence s_faulted;
		faultRelayFlash[*3];
	endsequence
	sequence s_quietFault;
		faultRelayFlash && qCnt_ff == 3'h7;
	endsequence
	property p_card;
		!programCardPresent |-> ##[1:4] (faultRelayFlash && programCardAjarLamp);
	endproperty
	property p_cable;
		!redInterfaceCablePresent |-> ##[1:4] (faultRelayFlash && diagnosticLamp);
	endproperty
	property p_supply; !logicSupplyOk |-> ##[1:4] logicSupplyFaultLamp; endproperty
	property p_hold; s_quietFault |=> faultRelayFlash; endproperty
	property p_frozen; s_faulted |-> $stable(greenLamp) && $stable(yellowLamp); endproperty
	property p_wdLate; (wdCnt_ff == WD_OLD + 4) && powerLamp |-> watchdogTimeoutFaultLamp; endproperty
	property p_wdEarly; $rose(watchdogTimeoutFaultLamp) |-> wdCnt_ff >= WD_NEW - 4; endproperty
	property p_boLate; boCnt_ff == BO_NEW + 4 |-> !powerLamp; endproperty
	property p_boEarly; $fell(powerLamp) |-> boCnt_ff >= BO_OLD - 4; endproperty
	property p_bus; hreadyout && !hresp && !(conflictLamp || dualLamp || clearanceLamp); endproperty
	a_card: assert property (p_card) else $error("card removal not flagged");
	a_cable: assert property (p_cable) else $error("cable loss not flagged");
	a_supply: assert property (p_supply) else $error("supply fault not flagged");
	a_hold: assert property (p_hold) else $error("fault relay released without reset");
	a_frozen: assert property (p_frozen) else $error("channel lamps moved while faulted");
	a_wdLate: assert property (p_wdLate) else $error("watchdog timeout missed");
	a_wdEarly: assert property (p_wdEarly) else $error("watchdog timeout too early");
	a_boLate: assert property (p_boLate) else $error("brown-out not qualified");
	a_boEarly: assert property (p_boEarly) else $error("brown-out qualified too early");
	a_bus: assert property (p_bus) else $error("bus response or unused lamp wrong");
endmodule : fault_monitor_assertions

bind traffic_conflict_monitor_faults fault_monitor_assertions #(.CH(CHANNELS),
	.WD_NEW(WATCHDOG_NEW), .WD_OLD(WATCHDOG_OLD), .BO_NEW(BROWNOUT_NEW), .BO_OLD(BROWNOUT_OLD))
	chk (.clock, .resetn, .hsel, .htrans, .hwrite, .hreadyout, .hresp, .watchdogIn,
	.programCardPresent, .redInterfaceCablePresent, .lineDropout, .logicSupplyOk,
	.frontPanelReset, .remoteReset, .faultRelayFlash, .yellowLamp, .greenLamp, .powerLamp,
	.logicSupplyFaultLamp, .watchdogTimeoutFaultLamp, .conflictLamp, .dualLamp,
	.clearanceLamp, .programCardAjarLamp, .diagnosticLamp);

/* File: tb/traffic_conflict_monitor_faults_bench.sv */
`timescale 1ns/1ps
module traffic_conflict_monitor_faults_bench
	import fault_monitor_pkg::*;
;
	localparam int WD_N = 100, WD_O = 150, BO_N = 80, BO_O = 20;
	logic clock, resetn, hsel, hwrite, hreadyout, hresp, rdPh, wdRun, watchdogIn, redEnable;
	logic [31:0] haddr, hwdata, hrdata, v;
	logic [1:0] htrans, specialFunction;
	logic [17:0] redIn, yellowIn, greenIn, redLamp, yellowLamp, greenLamp;
	logic outputRelayCommon, programCardPresent, redInterfaceCablePresent, lineDropout;
	logic logicSupplyOk, frontPanelReset, remoteReset, faultRelayFlash, powerLamp;
	logic supLamp, wdLamp, conflictLamp, redFailLamp, dualLamp, clearanceLamp, cardLamp, diagLamp;
	int nMismatch, comparisons, wd, bo;
	logic [31:0] expQ[$], mskQ[$];
	string nmQ[$];
	traffic_conflict_monitor_faults #(.RED_FAIL_NEW(100), .RED_FAIL_OLD(60), .WATCHDOG_NEW(WD_N),
		.WATCHDOG_OLD(WD_O), .BROWNOUT_NEW(BO_N), .BROWNOUT_OLD(BO_O)) DUT (.clock(clock),
		.resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .redIn(redIn), .yellowIn(yellowIn),
		.greenIn(greenIn), .specialFunction(specialFunction), .redEnable(redEnable),
		.outputRelayCommon(outputRelayCommon), .watchdogIn(watchdogIn),
		.programCardPresent(programCardPresent), .redInterfaceCablePresent(redInterfaceCablePresent),
		.lineDropout(lineDropout), .logicSupplyOk(logicSupplyOk), .frontPanelReset(frontPanelReset),
		.remoteReset(remoteReset), .faultRelayFlash(faultRelayFlash), .redLamp(redLamp),
		.yellowLamp(yellowLamp), .greenLamp(greenLamp), .powerLamp(powerLamp),
		.logicSupplyFaultLamp(supLamp), .watchdogTimeoutFaultLamp(wdLamp),
		.conflictLamp(conflictLamp), .redFailLamp(redFailLamp), .dualLamp(dualLamp),
		.clearanceLamp(clearanceLamp), .programCardAjarLamp(cardLamp), .diagnosticLamp(diagLamp));
	cabinet_model cab (.clock(clock), .wdRun(wdRun), .watchdogIn(watchdogIn), .redIn(redIn),
		.yellowIn(yellowIn), .greenIn(greenIn), .specialFunction(specialFunction),
		.redEnable(redEnable));
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			nMismatch++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task wt(input int n);
		repeat (n) @(posedge clock);
	endtask : wt
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		do @(posedge clock); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		rdPh <= !w;
		do @(posedge clock); while (hreadyout !== 1'b1);
		rdPh <= 1'b0;
	endtask : bus
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string nm);
		expQ.push_back(e);
		mskQ.push_back(m);
		nmQ.push_back(nm);
		bus(1'b0, a, 32'h0);
	endtask : rd
	task pulse(input bit remote);
		if (remote) remoteReset <= 1'b1;
		else frontPanelReset <= 1'b1;
		wt(3);
		remoteReset <= 1'b0;
		frontPanelReset <= 1'b0;
		wt(3);
	endtask : pulse
	task end_sim;
		$display("mismatches %0d comparisons %0d", nMismatch, comparisons);
		if (nMismatch == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_sim
	// read data is judged at the edge closing its data phase
	always @(posedge clock) begin
		if (rdPh) chk(nmQ.pop_front(), hrdata & mskQ.pop_front(), expQ.pop_front());
	end
	initial begin
		#(25ns * 20000);
		nMismatch++;
		end_sim();
	end
	initial begin
		{resetn, hsel, haddr, htrans, hwrite, hwdata, rdPh, outputRelayCommon} = '0;
		{lineDropout, frontPanelReset, remoteReset} = '0;
		{wdRun, programCardPresent, redInterfaceCablePresent, logicSupplyOk} = 4'hf;
		v = $urandom(32'hb113);
		wt(10);
		resetn <= 1'b1;
		wt(1);
		rd(ADDR_CONFIG, 0, '1, "config");
		rd(ADDR_RED_FAIL_EN, 0, '1, "enables");
		rd(ADDR_STATUS, 0, '1, "status");
		rd(8'h40, 0, '1, "unmapped");
		v = $urandom & 32'h1f;
		bus(1'b1, ADDR_CONFIG, v);
		rd(ADDR_CONFIG, v, '1, "config");
		bus(1'b1, ADDR_CONFIG, 32'h10);
		rd(ADDR_STATUS, 32'h80, 32'h80, "relayActive");
		outputRelayCommon <= 1'b1;
		wt(4);
		rd(ADDR_STATUS, 0, 32'h80, "relayActive");
		bus(1'b1, ADDR_CONFIG, 0);
		rd(ADDR_STATUS, 32'h80, 32'h80, "relayActive");
		outputRelayCommon <= 1'b0;
		bus(1'b1, ADDR_RED_FAIL_EN, 32'h3ffff);
		rd(ADDR_RED_FAIL_EN, 32'h3ffff, '1, "enables");
		wt(300);
		chk("redFailLamp", redFailLamp, 0);
		chk("redLamp", redLamp, 0);
		chk("greenLamp", greenLamp | yellowLamp, 0);
		rd(ADDR_FAULT_CH, 0, '1, "faultCh");
		rd(ADDR_RED_LAT, 0, '1, "redLat");
		rd(ADDR_YEL_LAT, 0, '1, "yelLat");
		rd(ADDR_GRN_LAT, 0, '1, "grnLat");
		programCardPresent <= 1'b0;
		wt(6);
		rd(ADDR_STATUS, 32'h3, 32'h13, "card");
		chk("flash", faultRelayFlash, 1);
		pulse(0);
		rd(ADDR_STATUS, 1, 1, "triggered");
		programCardPresent <= 1'b1;
		wt(6);
		rd(ADDR_STATUS, 1, 1, "triggered");
		pulse(0);
		rd(ADDR_STATUS, 0, '1, "status");
		chk("flash", faultRelayFlash, 0);
		{redInterfaceCablePresent, logicSupplyOk} <= 2'h0;
		wt(3);
		{redInterfaceCablePresent, logicSupplyOk} <= 2'h3;
		wt(6);
		rd(ADDR_STATUS, 32'h11, 32'h11, "cable");
		chk("diagLamp", diagLamp, 1);
		pulse(1);
		rd(ADDR_STATUS, 0, '1, "status");
		for (int i = 0; i < 2; i++) begin
			wd = i ? WD_N : WD_O;
			bo = i ? BO_N : BO_O;
			bus(1'b1, ADDR_CONFIG, i ? 32'hf : 32'h0);
			wdRun <= 1'b0;
			wt(wd - 20);
			chk("wdLamp", wdLamp, 0);
			wt(40);
			chk("wdLamp", wdLamp, 1);
			wdRun <= 1'b1;
			lineDropout <= 1'b1;
			wt(bo - 10);
			chk("powerLamp", powerLamp, 1);
			wt(20);
			chk("powerLamp", powerLamp, 0);
			lineDropout <= 1'b0;
			wt(10);
			// a write without the key must not clear anything
			bus(1'b1, ADDR_RESET_CMD, 32'h0);
			rd(ADDR_STATUS, i << ST_WATCHDOG, 1 << ST_WATCHDOG, "watchdog");
			bus(1'b1, ADDR_RESET_CMD, RESET_KEY);
			wt(4);
			rd(ADDR_STATUS, 0, '1, "status");
		end
		wt(5);
		end_sim();
	end
endmodule : traffic_conflict_monitor_faults_bench

/* File: verilog/duration_qualifier.sv */
`timescale 1ns/1ps
module duration_qualifier
	import fault_monitor_pkg::*;
#(
	parameter int WIDTH = 1,
	parameter int ON_CYCLES = FIELD_ON_CYC
) (
	input wire logic clock,
	input wire logic resetn,
	qual_if.filter q
);
	// -----------------------------------------------------------
	// per-bit counter; any drop restarts it
	// -----------------------------------------------------------
	localparam logic [CNT_W-1:0] LIMIT = CNT_W'(ON_CYCLES - 1);
	logic [CNT_W-1:0] count_ff [WIDTH];
	logic [WIDTH-1:0] qual_ff;
	assign q.qual = qual_ff;
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge clock or negedge resetn) begin
			if (!resetn) begin
				count_ff[i] <= '0;
				qual_ff[i] <= 1'b0;
			end else if (!q.raw[i]) begin
				count_ff[i] <= '0;
				qual_ff[i] <= 1'b0;
			end else if (count_ff[i] >= LIMIT) begin
				qual_ff[i] <= 1'b1;
			end else begin
				count_ff[i] <= count_ff[i] + CNT_W'(1);
			end
		end
	end
endmodule : duration_qualifier

/* File: verilog/fault_monitor_pkg.sv */
package fault_monitor_pkg;
	localparam int NUM_CHANNELS = 18;
	localparam int NUM_RED_CABLE_CHANNELS = 16;
	localparam int CLOCK_HZ = 40000000;
	// ---------------------------------------------------------------
	// timing figures in ms, with derived cycle counts
	// ---------------------------------------------------------------
	localparam int FIELD_ON_MS = 500;
	localparam int SPECIAL_ON_MS = 550;
	localparam int RED_FAIL_NEW_MS = 1350;
	localparam int RED_FAIL_OLD_MS = 850;
	localparam int WATCHDOG_NEW_MS = 1000;
	localparam int WATCHDOG_OLD_MS = 1500;
	localparam int BROWNOUT_NEW_MS = 400;
	localparam int BROWNOUT_OLD_MS = 80;
	localparam int CYCLES_PER_MS = CLOCK_HZ / 1000;
	localparam int FIELD_ON_CYC = FIELD_ON_MS * CYCLES_PER_MS;
	localparam int SPECIAL_ON_CYC = SPECIAL_ON_MS * CYCLES_PER_MS;
	localparam int RED_FAIL_NEW_CYC = RED_FAIL_NEW_MS * CYCLES_PER_MS;
	localparam int RED_FAIL_OLD_CYC = RED_FAIL_OLD_MS * CYCLES_PER_MS;
	localparam int WATCHDOG_NEW_CYC = WATCHDOG_NEW_MS * CYCLES_PER_MS;
	localparam int WATCHDOG_OLD_CYC = WATCHDOG_OLD_MS * CYCLES_PER_MS;
	localparam int BROWNOUT_NEW_CYC = BROWNOUT_NEW_MS * CYCLES_PER_MS;
	localparam int BROWNOUT_OLD_CYC = BROWNOUT_OLD_MS * CYCLES_PER_MS;
	localparam int CNT_W = 27;
	// ---------------------------------------------------------------
	// register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_RED_FAIL_EN = 8'h08;
	localparam logic [7:0] ADDR_FAULT_CH = 8'h0c;
	localparam logic [7:0] ADDR_RED_LAT = 8'h10;
	localparam logic [7:0] ADDR_YEL_LAT = 8'h14;
	localparam logic [7:0] ADDR_GRN_LAT = 8'h18;
	localparam logic [7:0] ADDR_RESET_CMD = 8'h1c;
	// config bits
	localparam int CFG_RED_FAIL_SEL = 0;
	localparam int CFG_WATCHDOG_SEL = 1;
	localparam int CFG_BROWNOUT_SEL = 2;
	localparam int CFG_WATCHDOG_LATCH = 3;
	localparam int CFG_RELAY_POLARITY = 4;
	localparam int CFG_W = 5;
	localparam logic [CFG_W-1:0] CFG_RESET = 5'h00;
	// status bits
	localparam int ST_TRIGGERED = 0;
	localparam int ST_CARD_AJAR = 1;
	localparam int ST_WATCHDOG = 2;
	localparam int ST_RED_FAIL = 3;
	localparam int ST_CABLE = 4;
	localparam int ST_BROWNOUT = 5;
	localparam int ST_SUPPLY = 6;
	localparam int ST_RELAY_ACTIVE = 7;
	localparam int ST_W = 8;
	localparam logic [31:0] RESET_KEY = 32'h00000001;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : fault_monitor_pkg

/* File: verilog/qual_if.sv */
`timescale 1ns/1ps
interface qual_if #(parameter int WIDTH = 1);
	logic [WIDTH-1:0] raw;
	logic [WIDTH-1:0] qual;
	modport filter (input raw, output qual);
	modport user (output raw, input qual);
endinterface : qual_if

/* File: verilog/traffic_conflict_monitor_faults.sv */
// Implementation choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module traffic_conflict_monitor_faults
	import fault_monitor_pkg::*;
#(
	parameter int CHANNELS = NUM_CHANNELS,
	parameter int RED_FAIL_NEW = RED_FAIL_NEW_CYC,
	parameter int RED_FAIL_OLD = RED_FAIL_OLD_CYC,
	parameter int WATCHDOG_NEW = WATCHDOG_NEW_CYC,
	parameter int WATCHDOG_OLD = WATCHDOG_OLD_CYC,
	parameter int BROWNOUT_NEW = BROWNOUT_NEW_CYC,
	parameter int BROWNOUT_OLD = BROWNOUT_OLD_CYC
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [CHANNELS-1:0] redIn,
	input wire logic [CHANNELS-1:0] yellowIn,
	input wire logic [CHANNELS-1:0] greenIn,
	input wire logic [1:0] specialFunction,
	input wire logic redEnable,
	input wire logic outputRelayCommon,
	input wire logic watchdogIn,
	input wire logic programCardPresent,
	input wire logic redInterfaceCablePresent,
	input wire logic lineDropout,
	input wire logic logicSupplyOk,
	input wire logic frontPanelReset,
	input wire logic remoteReset,
	output logic faultRelayFlash,
	output logic [CHANNELS-1:0] redLamp,
	output logic [CHANNELS-1:0] yellowLamp,
	output logic [CHANNELS-1:0] greenLamp,
	output logic powerLamp,
	output logic logicSupplyFaultLamp,
	output logic watchdogTimeoutFaultLamp,
	output logic conflictLamp,
	output logic redFailLamp,
	output logic dualLamp,
	output logic clearanceLamp,
	output logic programCardAjarLamp,
	output logic diagnosticLamp
);
	// -----------------------------------------------------------
	// field input qualification
	// -----------------------------------------------------------
	localparam int QW = 3 * CHANNELS;
	qual_if #(.WIDTH(QW)) fieldQ ();
	qual_if #(.WIDTH(3)) specialQ ();
	assign fieldQ.raw = {greenIn, yellowIn, redIn};
	// red enable shares the special-function timing path
	assign specialQ.raw = {redEnable, specialFunction};
	duration_qualifier #(.WIDTH(QW), .ON_CYCLES(FIELD_ON_CYC)) u_field (
		.clock(clock),
		.resetn(resetn),
		.q(fieldQ)
	);
	duration_qualifier #(.WIDTH(3), .ON_CYCLES(SPECIAL_ON_CYC)) u_special (
		.clock(clock),
		.resetn(resetn),
		.q(specialQ)
	);
	logic [CHANNELS-1:0] redQ, yellowQ, greenQ;
	assign redQ = fieldQ.qual[CHANNELS-1:0];
	assign yellowQ = fieldQ.qual[2*CHANNELS-1:CHANNELS];
	assign greenQ = fieldQ.qual[QW-1:2*CHANNELS];
	logic specialActive;
	logic redEnableQ;
	assign specialActive = |specialQ.qual[1:0];
	assign redEnableQ = specialQ.qual[2];

	// -----------------------------------------------------------
	// bus slave
	// -----------------------------------------------------------
	logic [CFG_W-1:0] config_ff;
	logic [CHANNELS-1:0] redFailEn_ff;
	logic wrPend_ff;
	logic [7:0] addr_ff;
	logic swReset_ff;
	logic [31:0] nxt_rdata;
	logic addrPhase;
	assign addrPhase = hsel && hready && htrans == HTRANS_NONSEQ;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wrPend_ff <= 1'b0;
			addr_ff <= '0;
		end else begin
			wrPend_ff <= addrPhase && hwrite;
			if (addrPhase) begin
				addr_ff <= haddr[7:0];
			end
		end
	end
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			config_ff <= CFG_RESET;
			redFailEn_ff <= '0;
			swReset_ff <= 1'b0;
		end else begin
			swReset_ff <= wrPend_ff && addr_ff == ADDR_RESET_CMD && hwdata == RESET_KEY;
			if (wrPend_ff && addr_ff == ADDR_CONFIG) begin
				config_ff <= hwdata[CFG_W-1:0];
			end
			if (wrPend_ff && addr_ff == ADDR_RED_FAIL_EN) begin
				redFailEn_ff <= hwdata[CHANNELS-1:0];
			end
		end
	end

	// -----------------------------------------------------------
	// timers and fault latching
	// -----------------------------------------------------------
	logic triggered_ff, cardFault_ff, watchdogFault_ff, redFail_ff, cableFault_ff;
	logic brownout_ff, supplyFault_ff;
	logic [CNT_W-1:0] wdCount_ff, brownCount_ff;
	logic [CNT_W-1:0] noIndCount_ff [CHANNELS];
	logic [CHANNELS-1:0] chanFail_ff, redLat_ff, yelLat_ff, grnLat_ff;
	logic wdPrev_ff;
	logic resetReq;
	logic relayActive;
	logic [CNT_W-1:0] redFailLimit, wdLimit, brownLimit;
	logic [CHANNELS-1:0] noIndTrip;
	logic redMonitorOn;
	logic brownoutQ;
	logic wdTrip;
	logic anyFault;
	assign relayActive = outputRelayCommon ^ config_ff[CFG_RELAY_POLARITY];
	assign redFailLimit = config_ff[CFG_RED_FAIL_SEL] ?
		CNT_W'(RED_FAIL_NEW) : CNT_W'(RED_FAIL_OLD);
	assign wdLimit = config_ff[CFG_WATCHDOG_SEL] ?
		CNT_W'(WATCHDOG_NEW) : CNT_W'(WATCHDOG_OLD);
	assign brownLimit = config_ff[CFG_BROWNOUT_SEL] ?
		CNT_W'(BROWNOUT_NEW) : CNT_W'(BROWNOUT_OLD);
	assign redMonitorOn = redEnableQ && !specialActive;
	assign resetReq = frontPanelReset || remoteReset || swReset_ff;
	assign brownoutQ = brownCount_ff >= brownLimit;
	assign wdTrip = wdCount_ff >= wdLimit;

	for (genvar c = 0; c < CHANNELS; c++) begin : g_noind
		assign noIndTrip[c] = noIndCount_ff[c] >= redFailLimit;
		always_ff @(posedge clock or negedge resetn) begin
			if (!resetn) begin
				noIndCount_ff[c] <= '0;
			end else if (!redMonitorOn || !redFailEn_ff[c] || redQ[c] || yellowQ[c]
				|| greenQ[c]) begin
				noIndCount_ff[c] <= '0;
			end else if (!noIndTrip[c]) begin
				noIndCount_ff[c] <= noIndCount_ff[c] + CNT_W'(1);
			end
		end
	end

	// watchdog counts time since its last edge
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wdPrev_ff <= 1'b0;
			wdCount_ff <= '0;
			brownCount_ff <= '0;
		end else begin
			wdPrev_ff <= watchdogIn;
			if (watchdogIn != wdPrev_ff) begin
				wdCount_ff <= '0;
			end else if (!wdTrip) begin
				wdCount_ff <= wdCount_ff + CNT_W'(1);
			end
			if (!lineDropout) begin
				brownCount_ff <= '0;
			end else if (!brownoutQ) begin
				brownCount_ff <= brownCount_ff + CNT_W'(1);
			end
		end
	end

	// set wins over reset for every latched fault; a persisting cause re-latches at once; brownout_ff simply follows brownoutQ
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cardFault_ff <= 1'b0;
			cableFault_ff <= 1'b0;
			redFail_ff <= 1'b0;
			supplyFault_ff <= 1'b0;
			brownout_ff <= 1'b0;
			chanFail_ff <= '0;
		end else begin
			if (!programCardPresent) begin
				cardFault_ff <= 1'b1;
			end else if (resetReq) begin
				cardFault_ff <= 1'b0;
			end
			if (!redInterfaceCablePresent) begin
				cableFault_ff <= 1'b1;
			end else if (resetReq) begin
				cableFault_ff <= 1'b0;
			end
			if (|noIndTrip) begin
				redFail_ff <= 1'b1;
			end else if (resetReq) begin
				redFail_ff <= 1'b0;
			end
			if (!logicSupplyOk) begin
				supplyFault_ff <= 1'b1;
			end else if (resetReq) begin
				supplyFault_ff <= 1'b0;
			end
			brownout_ff <= brownoutQ;
			if (!triggered_ff && |noIndTrip) begin
				chanFail_ff <= noIndTrip;
			end else if (resetReq && !(|noIndTrip)) begin
				chanFail_ff <= '0;
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			watchdogFault_ff <= 1'b0;
		end else if (wdTrip) begin
			watchdogFault_ff <= 1'b1;
		end else if (resetReq) begin
			watchdogFault_ff <= 1'b0;
		end else if (!config_ff[CFG_WATCHDOG_LATCH] && (brownoutQ || !logicSupplyOk)) begin
			watchdogFault_ff <= 1'b0;
		end
	end

	assign anyFault = cardFault_ff || cableFault_ff || redFail_ff || watchdogFault_ff
		|| supplyFault_ff;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			triggered_ff <= 1'b0;
			faultRelayFlash <= 1'b0;
		end else begin
			triggered_ff <= anyFault;
			faultRelayFlash <= anyFault;
		end
	end

	// -----------------------------------------------------------
	// channel indicators: live until triggered, then frozen
	// -----------------------------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			redLat_ff <= '0;
			yelLat_ff <= '0;
			grnLat_ff <= '0;
		end else if (!anyFault) begin
			redLat_ff <= redQ;
			yelLat_ff <= yellowQ;
			grnLat_ff <= greenQ;
		end
	end
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			redLamp <= '0;
			yellowLamp <= '0;
			greenLamp <= '0;
			powerLamp <= 1'b0;
			logicSupplyFaultLamp <= 1'b0;
			watchdogTimeoutFaultLamp <= 1'b0;
			conflictLamp <= 1'b0;
			redFailLamp <= 1'b0;
			dualLamp <= 1'b0;
			clearanceLamp <= 1'b0;
			programCardAjarLamp <= 1'b0;
			diagnosticLamp <= 1'b0;
		end else begin
			// failed channels shown on red while a red fail is held
			redLamp <= redFail_ff ? chanFail_ff : redLat_ff;
			yellowLamp <= yelLat_ff;
			greenLamp <= grnLat_ff;
			powerLamp <= !brownoutQ;
			logicSupplyFaultLamp <= supplyFault_ff;
			watchdogTimeoutFaultLamp <= watchdogFault_ff;
			conflictLamp <= 1'b0;
			redFailLamp <= redFail_ff;
			dualLamp <= 1'b0;
			clearanceLamp <= 1'b0;
			programCardAjarLamp <= cardFault_ff;
			diagnosticLamp <= cableFault_ff;
		end
	end

	// -----------------------------------------------------------
	// read data
	// -----------------------------------------------------------
	always_comb begin
		nxt_rdata = '0;
		unique case (haddr[7:0])
			ADDR_CONFIG: nxt_rdata[CFG_W-1:0] = config_ff;
			ADDR_STATUS: nxt_rdata[ST_W-1:0] = {relayActive, supplyFault_ff, brownout_ff,
				cableFault_ff, redFail_ff, watchdogFault_ff, cardFault_ff, triggered_ff};
			ADDR_RED_FAIL_EN: nxt_rdata[CHANNELS-1:0] = redFailEn_ff;
			ADDR_FAULT_CH: nxt_rdata[CHANNELS-1:0] = chanFail_ff;
			ADDR_RED_LAT: nxt_rdata[CHANNELS-1:0] = redLat_ff;
			ADDR_YEL_LAT: nxt_rdata[CHANNELS-1:0] = yelLat_ff;
			ADDR_GRN_LAT: nxt_rdata[CHANNELS-1:0] = grnLat_ff;
			default: nxt_rdata = '0;
		endcase
	end
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			hrdata <= '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (addrPhase && !hwrite) begin
				hrdata <= nxt_rdata;
			end
		end
	end
endmodule : traffic_conflict_monitor_faults
